// ==== rtl/ttm_pkg.sv ====
// constants shared by the trigger transmit mode loader
package ttm_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 8;
  localparam int         DATA_W      = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_COND  = 6'h20;
  localparam logic [5:0] IDX_CMASK = 6'h21;
  localparam logic [5:0] IDX_TSEL  = 6'h26;
  localparam logic [5:0] IDX_CUR_MODE = 6'h28;
  localparam logic [5:0] IDX_EVT   = 6'h2a;
  localparam logic [5:0] IDX_EMASK = 6'h2b;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         COND_FLAG_BIT  = 7;
  localparam int         CMASK_FLAG_BIT = 7;
  localparam int         TSEL_MODE_W   = 3;
  localparam int         TSEL_EN_LSB   = 3;
  localparam int         NSRC          = 5;
  localparam int         EVT_W         = 2;
  localparam int         EVT_SVC_BIT   = 0;
  localparam int         EVT_WREJ_BIT  = 1;
  localparam logic [7:0] TSEL_RST      = 8'h00;
  localparam logic [2:0] CUR_MODE_RST  = 3'h0;

  // ----------------------------------------------------------------
  // transmit modes and symbols
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_IDLE   = 3'h1;
  localparam logic [2:0] MODE_OFF    = 3'h2;
  localparam logic [2:0] MODE_RSV3   = 3'h3;
  localparam logic [2:0] MODE_MASTER = 3'h4;
  localparam logic [2:0] MODE_HALT   = 3'h5;
  localparam logic [2:0] MODE_QUIET  = 3'h6;
  localparam logic [2:0] MODE_RSV7   = 3'h7;
  localparam logic [4:0] SYM_IDLE    = 5'h1f;
  localparam logic [4:0] SYM_HALT    = 5'h04;
  localparam logic [4:0] SYM_QUIET   = 5'h00;

endpackage

// ==== rtl/ttm_core_if.sv ====
// internal carrier between control, trigger detector and encoder
`timescale 1ns/1ps
`default_nettype none
interface ttm_core_if;
  logic [4:0] src;
  logic [4:0] en;
  logic       fire;
  logic [2:0] mode;
  logic [9:0] req_pair;
  logic [9:0] tx_pair;
  logic       tx_en;
  modport det (input src, input en, output fire);
  modport enc (input mode, input req_pair, output tx_pair, output tx_en);
  modport ctl (output src, output en, output mode, output req_pair,
               input fire, input tx_pair, input tx_en);
endinterface
`default_nettype wire

// ==== rtl/ttm_trigger_detect.sv ====
// rising-edge detector over the enabled trigger sources
`timescale 1ns/1ps
`default_nettype none
module ttm_trigger_detect (
  input wire logic aclk,
  input wire logic aresetn,
  ttm_core_if.det  cif
);
  typedef struct packed {
    logic [4:0] prev;
  } ttm_det_s;

  ttm_det_s s;
  ttm_det_s next_s;

  // ----------------------------------------------------------------
  // source history
  // ----------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.prev = cif.src;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // any enabled source entering its condition
  assign cif.fire = |(cif.en & cif.src & ~s.prev);
endmodule
`default_nettype wire

// ==== rtl/ttm_tx_encoder.sv ====
// transmit symbol pair generator for the current transmit mode
`timescale 1ns/1ps
`default_nettype none
module ttm_tx_encoder (
  input wire logic aclk,
  input wire logic aresetn,
  ttm_core_if.enc  cif
);
  typedef struct packed {
    logic [9:0] pair;
    logic       tx_en;
  } ttm_enc_s;

  ttm_enc_s s;
  ttm_enc_s next_s;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    next_s.tx_en = 1'b1;
    unique case (cif.mode)
      ttm_pkg::MODE_ACTIVE: next_s.pair = cif.req_pair;
      ttm_pkg::MODE_IDLE:   next_s.pair = {ttm_pkg::SYM_IDLE, ttm_pkg::SYM_IDLE};
      ttm_pkg::MODE_OFF: begin
        next_s.pair = {ttm_pkg::SYM_QUIET, ttm_pkg::SYM_QUIET};
        next_s.tx_en = 1'b0;
      end
      ttm_pkg::MODE_MASTER: next_s.pair = {ttm_pkg::SYM_HALT, ttm_pkg::SYM_QUIET};
      ttm_pkg::MODE_HALT:   next_s.pair = {ttm_pkg::SYM_HALT, ttm_pkg::SYM_HALT};
      ttm_pkg::MODE_QUIET:  next_s.pair = {ttm_pkg::SYM_QUIET, ttm_pkg::SYM_QUIET};
      ttm_pkg::MODE_RSV3,
      ttm_pkg::MODE_RSV7:   next_s.pair = {ttm_pkg::SYM_QUIET, ttm_pkg::SYM_QUIET};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{pair: 10'h000, tx_en: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign cif.tx_pair = s.pair;
  assign cif.tx_en   = s.tx_en;
endmodule
`default_nettype wire

// ==== rtl/ttm_loader.sv ====
// trigger select register, transmit mode loader and register slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - trigger copies trigger mode into current mode
// - every trigger sets trigger-occurred flag
// - low three bits mode, upper five enables
// - active mode passes request pairs through
// - idle mode sends idle pairs
// - off mode sends quiet, drops optic enable
// - master mode sends halt then quiet
// - halt mode sends halt pairs
// - quiet mode sends quiet, optic enable on
// - reserved codes send quiet pairs
// - quiet line state triggers when enabled
// - noise counter at zero triggers when enabled
// - flag set protects current mode from writes
// - flag and mask set service event
module ttm_loader #(
  parameter int NOISE_W = 8
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ttm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [ttm_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ttm_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [ttm_pkg::DATA_W-1:0]  s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   ls_super_idle,
  input  wire logic                   ls_master,
  input  wire logic                   ls_halt,
  input  wire logic                   ls_quiet,
  input  wire logic [NOISE_W-1:0]     noise_count,
  input  wire logic [9:0]             req_pair,
  output logic [9:0]                  tx_pair,
  output logic                        optic_tx_enable,
  output logic                        irq
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (NOISE_W < 1 || NOISE_W > 16) begin : g_chk
    $error("noise counter width must be 1 to 16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        aw_held;
    logic [5:0]                  aw_idx;
    logic                        aw_bad;
    logic                        w_held;
    logic [7:0]                  wdata;
    logic                        wlane0;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [ttm_pkg::DATA_W-1:0]  rdata;
    logic [1:0]                  rresp;
    logic [7:0]                  trigger_select;
    logic [2:0]                  current_tx_state;
    logic                        trigger_occurred_flag;
    logic                        trigger_occurred_mask;
    logic [ttm_pkg::EVT_W-1:0]   evt;
    logic [ttm_pkg::EVT_W-1:0]   evt_mask;
    logic                        irq;
  } ttm_loader_s;

  ttm_loader_s s;
  ttm_loader_s next_s;
  ttm_core_if  cif ();

  logic             wr_go;
  logic             wr_cur_mode;
  logic             noise_zero;
  logic [7:0]       rd_val;
  logic             rd_ok;

  // ----------------------------------------------------------------
  // trigger sources and sub blocks
  // ----------------------------------------------------------------
  assign noise_zero   = (noise_count == '0);
  assign cif.src      = {noise_zero, ls_quiet, ls_halt, ls_master, ls_super_idle};
  assign cif.en       = s.trigger_select[7:ttm_pkg::TSEL_EN_LSB];
  assign cif.mode     = s.current_tx_state;
  assign cif.req_pair = req_pair;

  ttm_trigger_detect u_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif)
  );

  ttm_tx_encoder u_enc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif)
  );

  assign wr_go   = s.aw_held && s.w_held && !s.bvalid;
  assign wr_cur_mode = wr_go && !s.aw_bad && (s.aw_idx == ttm_pkg::IDX_CUR_MODE) && s.wlane0;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[ttm_pkg::ADDR_W-1] != 1'b1) begin
      rd_ok = 1'b0;
    end else begin
      unique case (s_axi_araddr[7:2])
        ttm_pkg::IDX_COND:  rd_val = {s.trigger_occurred_flag, 7'h00};
        ttm_pkg::IDX_CMASK: rd_val = {s.trigger_occurred_mask, 7'h00};
        ttm_pkg::IDX_TSEL:  rd_val = s.trigger_select;
        ttm_pkg::IDX_CUR_MODE: rd_val = {5'h00, s.current_tx_state};
        ttm_pkg::IDX_EVT:   rd_val = {6'h00, s.evt};
        ttm_pkg::IDX_EMASK: rd_val = {6'h00, s.evt_mask};
        default:            rd_ok  = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // write address and data, either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx  = s_axi_awaddr[7:2];
      next_s.aw_bad  = (s_axi_awaddr[1:0] != 2'h0);
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = ttm_pkg::RESP_OKAY;
      if (s.aw_bad) begin
        next_s.bresp = ttm_pkg::RESP_SLVERR;
      end else begin
        unique case (s.aw_idx)
          ttm_pkg::IDX_COND: begin
            if (s.wlane0 && s.wdata[ttm_pkg::COND_FLAG_BIT]) begin
              next_s.trigger_occurred_flag = 1'b0;
            end
          end
          ttm_pkg::IDX_CMASK: begin
            if (s.wlane0) begin
              next_s.trigger_occurred_mask = s.wdata[ttm_pkg::CMASK_FLAG_BIT];
            end
          end
          ttm_pkg::IDX_TSEL: begin
            if (s.wlane0) begin
              next_s.trigger_select = s.wdata;
            end
          end
          ttm_pkg::IDX_CUR_MODE: begin
            if (s.wlane0 && s.trigger_occurred_flag) begin
              next_s.evt[ttm_pkg::EVT_WREJ_BIT] = 1'b1;
            end else if (s.wlane0) begin
              next_s.current_tx_state = s.wdata[2:0];
            end
          end
          ttm_pkg::IDX_EVT: begin
            if (s.wlane0) begin
              next_s.evt = s.evt & ~s.wdata[ttm_pkg::EVT_W-1:0];
            end
          end
          ttm_pkg::IDX_EMASK: begin
            if (s.wlane0) begin
              next_s.evt_mask = s.wdata[ttm_pkg::EVT_W-1:0];
            end
          end
          default: next_s.bresp = ttm_pkg::RESP_SLVERR;
        endcase
      end
    end
    // read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = {24'h000000, rd_val};
      next_s.rresp  = rd_ok ? ttm_pkg::RESP_OKAY : ttm_pkg::RESP_SLVERR;
    end
    // trigger wins over a same-cycle write or clear
    if (cif.fire) begin
      next_s.current_tx_state      = s.trigger_select[ttm_pkg::TSEL_MODE_W-1:0];
      next_s.trigger_occurred_flag = 1'b1;
    end
    if (s.trigger_occurred_flag && s.trigger_occurred_mask) begin
      next_s.evt[ttm_pkg::EVT_SVC_BIT] = 1'b1;
    end
    next_s.irq     = |(next_s.evt & next_s.evt_mask);
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                <= '0;
      s.awready        <= 1'b1;
      s.wready         <= 1'b1;
      s.arready        <= 1'b1;
      s.trigger_select <= ttm_pkg::TSEL_RST;
      s.current_tx_state <= ttm_pkg::CUR_MODE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready   = s.awready;
  assign s_axi_wready    = s.wready;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_arready   = s.arready;
  assign s_axi_rvalid    = s.rvalid;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign tx_pair         = cif.tx_pair;
  assign optic_tx_enable = cif.tx_en;
  assign irq             = s.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mode_load: assert property (cif.fire |=> s.current_tx_state == $past(s.trigger_select[2:0]))
    else $error("trigger did not load transmit mode");
  a_flag_set: assert property (cif.fire |=> s.trigger_occurred_flag)
    else $error("trigger did not set flag");
  a_no_enable: assert property (s.trigger_select[7:3] == 5'h00 |-> !cif.fire)
    else $error("trigger fired with all enables clear");
  a_active_pass: assert property (s.current_tx_state == 3'h0 |=> tx_pair == $past(req_pair))
    else $error("active mode did not pass request data");
  a_idle_pair: assert property (s.current_tx_state == 3'h1 |=> tx_pair == 10'h3ff)
    else $error("idle mode pair wrong");
  a_off_mode: assert property (s.current_tx_state == 3'h2 |=> tx_pair == 10'h000 && !optic_tx_enable)
    else $error("off mode output wrong");
  a_master_pair: assert property (s.current_tx_state == 3'h4 |=> tx_pair == 10'h080)
    else $error("master mode pair wrong");
  a_halt_pair: assert property (s.current_tx_state == 3'h5 |=> tx_pair == 10'h084)
    else $error("halt mode pair wrong");
  a_quiet_mode: assert property (s.current_tx_state == 3'h6 |=> tx_pair == 10'h000 && optic_tx_enable)
    else $error("quiet mode output wrong");
  a_rsv_quiet: assert property (s.current_tx_state[1:0] == 2'h3 |=> tx_pair == 10'h000)
    else $error("reserved mode not quiet");
  a_quiet_src: assert property (s.trigger_select[6] && $rose(ls_quiet) |-> cif.fire)
    else $error("quiet line state missed");
  a_noise_src: assert property (s.trigger_select[7] && $rose(noise_zero) |-> cif.fire)
    else $error("noise limit missed");
  a_halt_src: assert property (s.trigger_select[5] && $rose(ls_halt) |=> s.trigger_occurred_flag)
    else $error("halt line state missed");
  a_cur_lock: assert property (wr_cur_mode && s.trigger_occurred_flag && !cif.fire
                                |=> $stable(s.current_tx_state) && s.evt[1])
    else $error("protected mode register changed");
  a_cse_set: assert property (s.trigger_occurred_flag && s.trigger_occurred_mask
                              |=> s.evt[0] ##1 irq || !s.evt_mask[0])
    else $error("service event not raised");
  a_irq_level: assert property (irq == |(s.evt & s.evt_mask))
    else $error("interrupt level wrong");
  a_cse_cause: assert property ($rose(s.evt[0]) |-> $past(s.trigger_occurred_flag && s.trigger_occurred_mask))
    else $error("service event without cause");
  a_reject_okay: assert property (wr_cur_mode |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("mode write response wrong");
  a_flag_hold: assert property (s.trigger_occurred_flag && !wr_go |=> s.trigger_occurred_flag)
    else $error("flag dropped without clear");
  a_mode_hold: assert property (!cif.fire && !wr_cur_mode |=> $stable(s.current_tx_state))
    else $error("mode changed without trigger or write");
  a_sel_write: assert property (wr_go && !s.aw_bad && s.aw_idx == ttm_pkg::IDX_TSEL && s.wlane0
                                |=> s.trigger_select == $past(s.wdata))
    else $error("select write lost");

  // ----------------------------------------------------------------
  // cover properties
  // ----------------------------------------------------------------
  c_trigger: cover property (cif.fire ##1 s.trigger_occurred_flag);
  c_reject:  cover property (wr_cur_mode && s.trigger_occurred_flag);
  c_noise:   cover property (cif.fire && noise_zero);
  c_irq:     cover property ($rose(irq));
  c_master:  cover property (s.current_tx_state == 3'h4 ##1 tx_pair == 10'h080);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking testbench for the trigger transmit mode loader
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // signals and register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_COND  = {ttm_pkg::IDX_COND, 2'b00};
  localparam logic [7:0] A_CMASK = {ttm_pkg::IDX_CMASK, 2'b00};
  localparam logic [7:0] A_TSEL  = {ttm_pkg::IDX_TSEL, 2'b00};
  localparam logic [7:0] A_CUR   = {ttm_pkg::IDX_CUR_MODE, 2'b00};
  localparam logic [7:0] A_EVT   = {ttm_pkg::IDX_EVT, 2'b00};
  localparam logic [7:0] A_EMASK = {ttm_pkg::IDX_EMASK, 2'b00};
  localparam logic [1:0] OK      = ttm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR     = ttm_pkg::RESP_SLVERR;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [4:0]  src;
  logic [7:0]  noise_nz;
  logic [9:0]  req_pair;
  logic [9:0]  tx_pair;
  logic        optic_tx_enable;
  logic        irq;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [33:0] re;
  logic [7:0]  regs[6];
  logic [9:0]  r;
  int          n_mismatch;
  int          n_compared;

  ttm_loader #(.NOISE_W(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ls_super_idle(src[0]), .ls_master(src[1]), .ls_halt(src[2]), .ls_quiet(src[3]),
    .noise_count(src[4] ? 8'h00 : noise_nz), .req_pair(req_pair),
    .tx_pair(tx_pair), .optic_tx_enable(optic_tx_enable), .irq(irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t output %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    bq.push_back(er);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      $display("BAD %0t write got no answer", $time);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    rq.push_back({er, 24'h0, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      $display("BAD %0t read got no answer", $time);
    end
    rready <= 1'b0;
  endtask

  function automatic logic [9:0] exp_pair(input logic [2:0] m, input logic [9:0] q);
    case (m)
      ttm_pkg::MODE_ACTIVE: return q;
      ttm_pkg::MODE_IDLE:   return {ttm_pkg::SYM_IDLE, ttm_pkg::SYM_IDLE};
      ttm_pkg::MODE_MASTER: return {ttm_pkg::SYM_HALT, ttm_pkg::SYM_QUIET};
      ttm_pkg::MODE_HALT:   return {ttm_pkg::SYM_HALT, ttm_pkg::SYM_HALT};
      default:              return {ttm_pkg::SYM_QUIET, ttm_pkg::SYM_QUIET};
    endcase
  endfunction

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // response monitor
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) begin
      if (bq.size() == 0) chk(32'hdead, 32'h0);
      else chk({30'h0, bresp}, {30'h0, bq.pop_front()});
    end
    if (rvalid === 1'b1 && rready) begin
      if (rq.size() == 0) chk(32'hdead, 32'h0);
      else begin
        re = rq.pop_front();
        chk({30'h0, rresp}, {30'h0, re[33:32]});
        chk(rdata, re[31:0]);
      end
    end
  end

  initial begin
    repeat (50000) @(posedge aclk);
    n_mismatch++;
    test_done;
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h3afa));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, src, req_pair} = '0;
    noise_nz = 8'h3c;
    regs = '{A_COND, A_CMASK, A_TSEL, A_CUR, A_EVT, A_EMASK};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and unmapped places
    for (int i = 0; i < 6; i++) rd(regs[i], 8'h00, OK);
    rd(8'h00, 8'h00, ERR);
    rd(8'h9c, 8'h00, ERR);
    rd(8'h99, 8'h00, ERR);
    wr(8'h9c, 8'h55, ERR);
    // pass-through in active mode
    for (int i = 0; i < 4; i++) begin
      r = 10'($urandom);
      req_pair <= r;
      repeat (2) @(posedge aclk);
      chk(tx_pair, r);
      chk(optic_tx_enable, 1'b1);
    end
    // every mode loaded, one source per mode, sources taken in turn
    for (int m = 0; m < 8; m++) begin
      wr(A_TSEL, 8'(1 << (3 + m % 5)) | 8'(m), OK);
      rd(A_TSEL, 8'(1 << (3 + m % 5)) | 8'(m), OK);
      wr(A_COND, 8'h80, OK);
      r = 10'($urandom);
      req_pair <= r;
      noise_nz <= 8'($urandom_range(255, 1));
      src[m % 5] <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(tx_pair, exp_pair(3'(m), r));
      chk(optic_tx_enable, m != 2);
      src <= '0;
      rd(A_CUR, 8'(m), OK);
      rd(A_COND, 8'h80, OK);
    end
    // no enable set: no reload
    wr(A_TSEL, 8'h05, OK);
    wr(A_COND, 8'h80, OK);
    src <= 5'h1f;
    repeat (3) @(posedge aclk);
    chk(tx_pair, exp_pair(3'h7, r));
    src <= '0;
    rd(A_COND, 8'h00, OK);
    rd(A_CUR, 8'h07, OK);
    // flag protects the current mode
    wr(A_TSEL, 8'h21, OK);
    src[2] <= 1'b1;
    repeat (2) @(posedge aclk);
    src <= '0;
    wr(A_CUR, 8'h06, OK);
    rd(A_CUR, 8'h01, OK);
    rd(A_EVT, 8'h02, OK);
    wr(A_EVT, 8'h02, OK);
    wr(A_COND, 8'h80, OK);
    wr(A_CUR, 8'h05, OK);
    rd(A_CUR, 8'h05, OK);
    repeat (2) @(posedge aclk);
    chk(tx_pair, exp_pair(3'h5, r));
    // service event and interrupt
    wr(A_EMASK, 8'h01, OK);
    wr(A_CMASK, 8'h80, OK);
    chk(irq, 1'b0);
    src[2] <= 1'b1;
    repeat (4) @(posedge aclk);
    src <= '0;
    chk(irq, 1'b1);
    rd(A_EVT, 8'h01, OK);
    wr(A_EMASK, 8'h00, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(A_COND, 8'h80, OK);
    wr(A_EVT, 8'h01, OK);
    wr(A_EMASK, 8'h01, OK);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rd(A_EVT, 8'h00, OK);
    repeat (4) @(posedge aclk);
    test_done;
  end
endmodule
`default_nettype wire
